// ---- core/sie_pkg.sv ----
package sie_pkg;

	// Clock and timebase
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned MS_NS         = 1000000;
	localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
	localparam int unsigned TICK_W        = 16;

	// Timing figures in milliseconds
	localparam logic [9:0] TWO_HAND_WINDOW_MS = 10'h1f4;
	localparam logic [7:0] FILTER_MIN_MS      = 8'h03;
	localparam logic [7:0] FILTER_MAX_MS      = 8'hfa;
	localparam logic [3:0] TEST_PERIOD_MS     = 4'h8;

	// Register byte offsets
	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_FILTER = 4'h4;
	localparam logic [3:0] OFS_SIMUL  = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hc;

	// Reset values
	localparam logic [13:0] CTRL_RESET   = 14'h0000;
	localparam logic [7:0]  FILTER_RESET = 8'h03;
	localparam logic [9:0]  SIMUL_RESET  = 10'h0c8;

	// Control word fields (bit positions match sie_cfg_s packing)
	localparam int unsigned CTRL_KIND_LSB  = 0;
	localparam int unsigned CTRL_ALT_BIT   = 6;
	localparam int unsigned CTRL_RSTEN_BIT = 7;
	localparam int unsigned CTRL_RSTMON_BIT = 8;
	localparam int unsigned CTRL_SU_BIT    = 9;
	localparam int unsigned CTRL_ERR_BIT   = 10;
	localparam int unsigned CTRL_PULSE_BIT = 11;
	localparam int unsigned CTRL_SIM_BIT   = 12;
	localparam int unsigned CTRL_RUN_BIT   = 13;
	localparam int unsigned CTRL_W         = 14;

	// Status word fields
	localparam int unsigned ST_OUT_BIT   = 0;
	localparam int unsigned ST_FAULT_BIT = 1;
	localparam int unsigned ST_SIM_BIT   = 2;
	localparam int unsigned ST_SHORT_BIT = 3;
	localparam int unsigned ST_CFG_BIT   = 4;
	localparam int unsigned ST_SU_BIT    = 5;
	localparam int unsigned ST_OPEN_BIT  = 6;
	localparam int unsigned ST_FILT_LSB  = 7;

	// Fixed logic levels of the chained-controller input
	localparam logic constant_high_level = 1'b1;
	localparam logic constant_low_level  = 1'b0;

	// Kind of field device evaluated
	typedef enum logic [5:0] {
		KIND_TWO_HAND = 6'h01,
		KIND_SENSOR   = 6'h02,
		KIND_MAT      = 6'h04,
		KIND_SWITCH   = 6'h08,
		KIND_GRIP     = 6'h10,
		KIND_CHAIN    = 6'h20
	} sie_kind_e;

	typedef enum logic [2:0] {
		SU_WAIT_ACT = 3'h1,
		SU_WAIT_CLR = 3'h2,
		SU_DONE     = 3'h4
	} sie_su_e;

	typedef enum logic [2:0] {
		RS_LOCKED = 3'h1,
		RS_ARMED  = 3'h2,
		RS_OPEN   = 3'h4
	} sie_rst_e;

	typedef struct packed {
		logic       run;
		logic       simul_en;
		logic       pulse_en;
		logic       err_en;
		logic       startup_en;
		logic       rst_monitored;
		logic       rst_en;
		logic       alt_type;
		logic [5:0] kind;
	} sie_cfg_s;

endpackage

// ---- core/sie_input_evaluator.sv ----
// The implementer's own choices: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none

module sie_input_evaluator
#(
	parameter int unsigned TICK_CYCLES = sie_pkg::MS_CYCLES
)
(
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        contact_input_first,
	input  wire logic        contact_input_second,
	input  wire logic        contact_input_third,
	input  wire logic        contact_input_fourth,
	input  wire logic        reset_input,
	input  wire logic        master_unit,
	output logic      [1:0]  test_pulse_out,
	output logic             block_out,
	output logic             fault_out
);

	// Byte-lane merge, used by every writable register
	function automatic logic [31:0] merge_be(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return r;
	endfunction

	// Out-of-range filter settings are pulled to the nearest legal value
	function automatic logic [7:0] clamp_filter(input logic [7:0] v);
		if (v < sie_pkg::FILTER_MIN_MS)
			return sie_pkg::FILTER_MIN_MS;
		else if (v > sie_pkg::FILTER_MAX_MS)
			return sie_pkg::FILTER_MAX_MS;
		else
			return v;
	endfunction

	sie_pkg::sie_cfg_s cfg_ff;
	logic [7:0]        filter_ff;
	logic [9:0]        simul_ff;
	logic              ack_ff;
	localparam int unsigned TICK_W_L = sie_pkg::TICK_W;
	logic [31:0]       rdata_ff;
	logic [TICK_W_L-1:0] tick_cnt_ff;
	logic              tick;
	logic [4:0]        raw;
	logic [4:0]        raw_eff;
	logic [4:0]        filt_ff;
	logic [4:0]        nxt_filt;
	logic [7:0]        db_cnt_ff [5];
	logic [7:0]        nxt_db_cnt [5];
	logic [7:0]        filt_ms;
	logic [3:0]        tp_cnt_ff;
	logic              tp_sel_ff;
	logic              tp_active_ff;
	logic [1:0]        short_ff;
	logic              sim_fault_ff;
	logic [9:0]        sim_cnt_ff;
	logic              mismatch;
	logic              sim_on;
	logic              th_released_ff;
	logic              th_armed_ff;
	logic              th_timing_ff;
	logic [9:0]        th_timer_ff;
	logic              btn_a;
	logic              btn_b;
	logic              cond;
	logic              cfg_fault;
	logic              fault;
	logic              act_high;
	logic              act_seen;
	logic              clr_seen;
	logic              cond_d_ff;
	logic              rst_rise;
	logic              rst_fall;
	logic              rst_d_ff;
	sie_pkg::sie_su_e  su_ff;
	sie_pkg::sie_su_e  nxt_su;
	sie_pkg::sie_rst_e rs_ff;
	sie_pkg::sie_rst_e nxt_rs;
	logic              out_ff;
	logic              fault_ff;

	// Bus decode: one wait cycle, then the answer
	wire       bus_req   = avs_read | avs_write;
	wire       wr_take   = avs_write & ack_ff;
	wire       sel_ctrl  = avs_address == sie_pkg::OFS_CTRL;
	wire       sel_filt  = avs_address == sie_pkg::OFS_FILTER;
	wire       sel_simul = avs_address == sie_pkg::OFS_SIMUL;
	wire       sel_stat  = avs_address == sie_pkg::OFS_STATUS;
	wire [31:0] ctrl_word  = {{(32-sie_pkg::CTRL_W){1'b0}}, cfg_ff};
	wire [31:0] filt_word  = {24'h000000, filter_ff};
	wire [31:0] simul_word = {22'h000000, simul_ff};
	wire [31:0] stat_word  = {20'h00000, filt_ff, rs_ff == sie_pkg::RS_OPEN,
		su_ff == sie_pkg::SU_DONE, cfg_fault, |short_ff, sim_fault_ff, fault, out_ff};
	wire [31:0] ctrl_new   = merge_be(ctrl_word, avs_writedata, avs_byteenable);
	wire [31:0] filt_new   = merge_be(filt_word, avs_writedata, avs_byteenable);
	wire [31:0] simul_new  = merge_be(simul_word, avs_writedata, avs_byteenable);
	wire [31:0] rd_mux     = sel_ctrl ? ctrl_word : sel_filt ? filt_word :
		sel_simul ? simul_word : sel_stat ? stat_word : 32'h00000000;

	assign avs_waitrequest = bus_req & ~ack_ff;
	assign avs_readdata    = rdata_ff;

	// Acknowledge and read data; unmapped reads answer zero
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h00000000;
		end
		else
		begin
			ack_ff   <= bus_req & ~ack_ff;
			rdata_ff <= (avs_read & ~ack_ff) ? rd_mux : rdata_ff;
		end
	end

	// Configuration registers; status is read-only
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cfg_ff    <= sie_pkg::CTRL_RESET;
			filter_ff <= sie_pkg::FILTER_RESET;
			simul_ff  <= sie_pkg::SIMUL_RESET;
		end
		else
		begin
			if (wr_take && sel_ctrl)
				cfg_ff <= ctrl_new[sie_pkg::CTRL_W-1:0];
			if (wr_take && sel_filt)
				filter_ff <= filt_new[7:0];
			if (wr_take && sel_simul)
				simul_ff <= simul_new[9:0];
		end
	end

	// Millisecond timebase
	assign tick = tick_cnt_ff == TICK_W_L'(TICK_CYCLES - 1);

	always_ff @(posedge clk)
	begin
		if (srst)
			tick_cnt_ff <= '0;
		else
			tick_cnt_ff <= tick ? '0 : tick_cnt_ff + TICK_W_L'(1);
	end

	// Pulse test: each output drops for one ms in turn, one output per mat input
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			tp_cnt_ff    <= 4'h0;
			tp_sel_ff    <= 1'b0;
			tp_active_ff <= 1'b0;
			short_ff     <= 2'b00;
		end
		else if (!cfg_ff.pulse_en)
		begin
			tp_cnt_ff    <= 4'h0;
			tp_active_ff <= 1'b0;
			short_ff     <= 2'b00;
		end
		else if (tick)
		begin
			tp_cnt_ff    <= (tp_cnt_ff == sie_pkg::TEST_PERIOD_MS - 4'h1) ? 4'h0 : tp_cnt_ff + 4'h1;
			tp_active_ff <= tp_cnt_ff == sie_pkg::TEST_PERIOD_MS - 4'h1;
			if (tp_active_ff)
			begin
				// A return that stays high while its feed is low is shorted
				short_ff[tp_sel_ff] <= raw[tp_sel_ff];
				tp_sel_ff           <= ~tp_sel_ff;
			end
		end
	end

	// Outputs idle high so the contacts carry a live level
	always_ff @(posedge clk)
	begin
		if (srst)
			test_pulse_out <= 2'b11;
		else
			test_pulse_out <= {~(tp_active_ff & tp_sel_ff), ~(tp_active_ff & ~tp_sel_ff)};
	end

	// Reset input sits on the input after the last contact
	assign raw = {reset_input, contact_input_fourth, contact_input_third,
		contact_input_second, contact_input_first};
	assign filt_ms = clamp_filter(filter_ff);

	// The channel under test is frozen so the test dip never reaches the filter
	always_comb
	begin
		raw_eff = raw;
		if (tp_active_ff)
			raw_eff[tp_sel_ff] = filt_ff[tp_sel_ff];
	end

	// Debounce: one extra tick guarantees the full time despite tick phase
	always_comb
	begin
		nxt_filt = filt_ff;
		for (int i = 0; i < 5; i++)
		begin
			nxt_db_cnt[i] = db_cnt_ff[i];
			if (raw_eff[i] == filt_ff[i])
				nxt_db_cnt[i] = 8'h00;
			else if (tick)
			begin
				if (db_cnt_ff[i] >= filt_ms)
				begin
					nxt_filt[i]   = raw_eff[i];
					nxt_db_cnt[i] = 8'h00;
				end
				else
					nxt_db_cnt[i] = db_cnt_ff[i] + 8'h01;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			filt_ff   <= 5'h00;
			db_cnt_ff <= '{default: 8'h00};
		end
		else
		begin
			filt_ff   <= nxt_filt;
			db_cnt_ff <= nxt_db_cnt;
		end
	end

	// Two-hand buttons: quad type uses NO on first/third and NC on second/fourth
	assign btn_a = cfg_ff.alt_type ? filt_ff[0] & ~filt_ff[1] : filt_ff[0];
	assign btn_b = cfg_ff.alt_type ? filt_ff[2] & ~filt_ff[3] : filt_ff[1];

	// Pairs of contacts checked per device kind: quad two-hand pairs must differ, mat, grip and double chain pairs must agree
	always_comb
	begin
		mismatch = 1'b0;
		sim_on   = cfg_ff.simul_en;
		case (cfg_ff.kind)
			sie_pkg::KIND_TWO_HAND:
				mismatch = cfg_ff.alt_type & ((filt_ff[0] == filt_ff[1]) | (filt_ff[2] == filt_ff[3]));
			sie_pkg::KIND_GRIP:
			begin
				sim_on   = 1'b1;
				mismatch = filt_ff[0] != filt_ff[1];
			end
			sie_pkg::KIND_MAT:
				mismatch = filt_ff[0] != filt_ff[1];
			sie_pkg::KIND_CHAIN:
				mismatch = cfg_ff.alt_type & (filt_ff[0] != filt_ff[1]);
			default:
				mismatch = 1'b0;
		endcase
	end

	// Simultaneity: the error clears once the contacts agree again or the check is switched off
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			sim_cnt_ff   <= 10'h000;
			sim_fault_ff <= 1'b0;
		end
		else if (!sim_on || !mismatch)
		begin
			sim_cnt_ff   <= 10'h000;
			sim_fault_ff <= 1'b0;
		end
		else if (tick)
		begin
			sim_cnt_ff   <= (sim_cnt_ff == 10'h3ff) ? sim_cnt_ff : sim_cnt_ff + 10'h001;
			sim_fault_ff <= sim_fault_ff | (sim_cnt_ff >= simul_ff);
		end
	end

	// Two-hand window: a new cycle needs both released first
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			th_released_ff <= 1'b0;
			th_armed_ff    <= 1'b0;
			th_timing_ff   <= 1'b0;
			th_timer_ff    <= 10'h000;
		end
		else if (!btn_a && !btn_b)
		begin
			th_released_ff <= 1'b1;
			th_armed_ff    <= 1'b0;
			th_timing_ff   <= 1'b0;
			th_timer_ff    <= 10'h000;
		end
		else if (btn_a && btn_b)
		begin
			th_armed_ff    <= th_armed_ff | th_released_ff;
			th_released_ff <= 1'b0;
			th_timing_ff   <= 1'b0;
		end
		else
		begin
			// Only one button down: count the window, drop arming
			th_armed_ff  <= 1'b0;
			th_timing_ff <= th_released_ff;
			if (th_released_ff && tick)
				th_timer_ff <= th_timer_ff + 10'h001;
			if (th_timing_ff && th_timer_ff >= sie_pkg::TWO_HAND_WINDOW_MS)
				th_released_ff <= 1'b0;
		end
	end

	// Evaluated input condition per kind
	always_comb
	begin
		cond      = 1'b0;
		cfg_fault = 1'b0;
		case (cfg_ff.kind)
			sie_pkg::KIND_TWO_HAND:
				cond = btn_a & btn_b & th_armed_ff;
			sie_pkg::KIND_SENSOR:
				cond = filt_ff[0];
			sie_pkg::KIND_MAT:
			begin
				cond      = filt_ff[0] & filt_ff[1];
				cfg_fault = ~cfg_ff.pulse_en;
			end
			sie_pkg::KIND_SWITCH:
				cond = filt_ff[0];
			sie_pkg::KIND_GRIP:
				cond = filt_ff[0] & filt_ff[1] & (~cfg_ff.alt_type | filt_ff[2]);
			sie_pkg::KIND_CHAIN:
			begin
				if (!master_unit)
				begin
					cond      = sie_pkg::constant_low_level;
					cfg_fault = 1'b1;
				end
				else if (cfg_ff.alt_type ? filt_ff[0] & filt_ff[1] : filt_ff[0])
					cond = sie_pkg::constant_high_level;
				else
					cond = sie_pkg::constant_low_level;
			end
			default:
				cfg_fault = 1'b1;
		endcase
	end

	assign fault = sim_fault_ff | (|short_ff) | cfg_fault;

	// Start-up test: hand devices are activated by pressing, sensors by occupying
	assign act_high = cfg_ff.kind == sie_pkg::KIND_TWO_HAND ||
		cfg_ff.kind == sie_pkg::KIND_GRIP || cfg_ff.kind == sie_pkg::KIND_SWITCH;
	assign act_seen = act_high ? cond : ~cond;
	assign clr_seen = ~act_seen;

	always_comb
	begin
		nxt_su = su_ff;
		case (su_ff)
			sie_pkg::SU_WAIT_ACT:
				if (cfg_ff.run && !cfg_ff.startup_en)
					nxt_su = sie_pkg::SU_DONE;
				else if (cfg_ff.run && act_seen && !fault)
					nxt_su = sie_pkg::SU_WAIT_CLR;
			sie_pkg::SU_WAIT_CLR:
				if (clr_seen && !fault)
					nxt_su = sie_pkg::SU_DONE;
			sie_pkg::SU_DONE:
				nxt_su = sie_pkg::SU_DONE;
			default:
				nxt_su = sie_pkg::SU_WAIT_ACT;
		endcase
	end

	// Reset input edges taken from the filtered copy
	assign rst_rise = filt_ff[4] & ~rst_d_ff;
	assign rst_fall = ~filt_ff[4] & rst_d_ff;

	always_comb
	begin
		nxt_rs = rs_ff;
		case (rs_ff)
			sie_pkg::RS_LOCKED:
				if (cond && rst_rise)
					nxt_rs = cfg_ff.rst_monitored ? sie_pkg::RS_ARMED : sie_pkg::RS_OPEN;
			sie_pkg::RS_ARMED:
				if (!cond)
					nxt_rs = sie_pkg::RS_LOCKED;
				else if (rst_fall)
					nxt_rs = sie_pkg::RS_OPEN;
			sie_pkg::RS_OPEN:
				if (!cond && cond_d_ff)
					nxt_rs = sie_pkg::RS_LOCKED;
			default:
				nxt_rs = sie_pkg::RS_LOCKED;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			su_ff     <= sie_pkg::SU_WAIT_ACT;
			rs_ff     <= sie_pkg::RS_LOCKED;
			rst_d_ff  <= 1'b0;
			cond_d_ff <= 1'b0;
		end
		else
		begin
			su_ff     <= nxt_su;
			rs_ff     <= nxt_rs;
			rst_d_ff  <= filt_ff[4];
			cond_d_ff <= cond;
		end
	end

	// Final output: any fault forces 0; fault flag only when selected
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			out_ff   <= 1'b0;
			fault_ff <= 1'b0;
		end
		else
		begin
			out_ff   <= cfg_ff.run & (su_ff == sie_pkg::SU_DONE) & cond & ~fault &
				(~cfg_ff.rst_en | rs_ff == sie_pkg::RS_OPEN);
			fault_ff <= cfg_ff.err_en & fault;
		end
	end

	assign block_out = out_ff;
	assign fault_out = fault_ff;

endmodule

`default_nettype wire

// ---- verification/sie_input_evaluator_props.sv ----
`timescale 1ns/10ps
`default_nettype none

module sie_input_evaluator_props
#(
	parameter int unsigned TICK_CYCLES = sie_pkg::MS_CYCLES
)
(
	input wire logic        clk,
	input wire logic        srst,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [1:0]  test_pulse_out,
	input wire logic        block_out,
	input wire logic        fault_out
);
	logic [15:0] dip_cnt_ff;
	logic [15:0] nxt_dip_cnt;
	wire         req;
	wire         unmapped;

	// Request and decode views; only 0, 4, 8 and c are mapped
	assign req = avs_read | avs_write;
	assign unmapped = avs_address[1:0] != 2'h0;
	assign nxt_dip_cnt = test_pulse_out[0] ? 16'h0 : dip_cnt_ff + 16'h1;

	// Length of a dip on the first test line; a stuck low line would blind the mat
	always_ff @(posedge clk)
	begin
		dip_cnt_ff <= srst ? 16'h0 : nxt_dip_cnt;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	sequence bus_wait_s;
		req && avs_waitrequest;
	endsequence
	sequence bus_done_s;
		req && !avs_waitrequest;
	endsequence

	wait_first_a: assert property ($rose(req) |-> avs_waitrequest)
		else $error("new request not held off");
	one_wait_a: assert property (bus_wait_s |=> bus_done_s)
		else $error("bus wait longer than one cycle");
	idle_ready_a: assert property (!req |-> !avs_waitrequest)
		else $error("waitrequest without request");
	unmapped_zero_a: assert property (avs_read && !avs_waitrequest && unmapped |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved without read");
	reset_quiet_a: assert property ($fell(srst) |-> !block_out && !fault_out && test_pulse_out == 2'h3)
		else $error("outputs not quiet after reset");
	pulse_apart_a: assert property (test_pulse_out != 2'h0)
		else $error("both test lines low");
	pulse_len_a: assert property (dip_cnt_ff <= TICK_CYCLES)
		else $error("test dip too long");
	fault_block_a: assert property (fault_out [*2] |-> !block_out)
		else $error("output high during fault");
endmodule

`default_nettype wire

// ---- verification/sie_field_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module sie_field_model
(
	input wire logic  [3:0] cmd,
	input wire logic        rst_cmd,
	input wire logic        mat_mode,
	input wire logic        short_mode,
	input wire logic  [1:0] test_pulse_out,
	output logic      [3:0] contact,
	output logic            reset_input
);
	// A mat contact passes its own test line only, so a dip shows on one input; a short
	// ties the first input high so the dip never comes back
	assign contact[0] = cmd[0] & (mat_mode ? (test_pulse_out[0] | short_mode) : 1'b1);
	assign contact[1] = cmd[1] & (mat_mode ? test_pulse_out[1] : 1'b1);
	assign contact[3:2] = cmd[3:2];
	// Reset button sits on the line after the last contact
	assign reset_input = rst_cmd;
endmodule

`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none

module testbench;
	localparam int unsigned TK = 4;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        master_unit = 1'b1;
	logic [3:0]  cmd = 4'h0;
	logic        rst_cmd = 1'b0;
	logic        mat_mode = 1'b0;
	logic        short_mode = 1'b0;
	wire  [3:0]  pin;
	wire         rst_pin;
	logic [1:0]  test_pulse_out;
	logic        block_out;
	logic        fault_out;
	logic [31:0] rd;
	logic [15:0] lfsr_q = 16'h0055;
	int          fail_count = 0;
	int          checks_done = 0;
	logic [5:0]  kinds [3] = '{6'h08, 6'h02, 6'h20};
	logic [2:0]  pos [4] = '{3'h4, 3'h7, 3'h4, 3'h0};

	sie_input_evaluator #(.TICK_CYCLES(TK)) sie_input_evaluator_i (.clk(clk), .srst(srst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .contact_input_first(pin[0]),
		.contact_input_second(pin[1]), .contact_input_third(pin[2]),
		.contact_input_fourth(pin[3]), .reset_input(rst_pin), .master_unit(master_unit),
		.test_pulse_out(test_pulse_out), .block_out(block_out), .fault_out(fault_out));
	sie_field_model sie_field_model_i (.cmd(cmd), .rst_cmd(rst_cmd), .mat_mode(mat_mode),
		.short_mode(short_mode), .test_pulse_out(test_pulse_out), .contact(pin),
		.reset_input(rst_pin));

	// Clock at 40 MHz
	initial
	begin
		forever #12.5 clk = ~clk;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic grip_out(input logic [2:0] p);
		return p[0] & p[1] & p[2];
	endfunction

	task summarize();
		if (fail_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One bus cycle; the request stands until waitrequest is seen low
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0 && n < 50)
		begin
			@(posedge clk);
			n++;
		end
		if (n == 50)
			fail_count++;
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task cfg(input logic [7:0] hi, input logic [5:0] kind);
		bus(1'b1, sie_pkg::OFS_CTRL, {18'h0, hi, kind});
	endtask
	task drive(input logic [3:0] v);
		@(posedge clk);
		cmd <= v;
	endtask
	task press(input logic v);
		@(posedge clk);
		rst_cmd <= v;
	endtask
	task ms(input int n);
		repeat (n * TK) @(posedge clk);
	endtask
	task wait_pin(input string nm, input logic f, input logic exp);
		int n;
		n = 0;
		while (((f ? fault_out : block_out) !== exp) && n < 4000)
		begin
			@(posedge clk);
			n++;
		end
		check(nm, {31'h0, f ? fault_out : block_out}, {31'h0, exp});
	endtask

	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		bus(1'b0, sie_pkg::OFS_FILTER, 32'h0);
		check("filter reset", rd, 32'h3);
		bus(1'b0, 4'h2, 32'h0);
		check("unmapped", rd, 32'h0);
		for (int i = 0; i < 6; i++)
		begin
			lfsr_q = lfsr(lfsr_q);
			bus(1'b1, sie_pkg::OFS_FILTER, i == 0 ? 32'h0 : i == 1 ? 32'hff : {16'h0, lfsr_q});
			bus(1'b0, sie_pkg::OFS_FILTER, 32'h0);
			check("filter", rd, i == 0 ? 32'h0 : i == 1 ? 32'hff : {24'h0, lfsr_q[7:0]});
		end
		// Register keeps the raw byte; zero must still filter as the 3 ms floor, which the
		// early checks below would catch
		bus(1'b1, sie_pkg::OFS_FILTER, 32'h0);
		bus(1'b1, sie_pkg::OFS_SIMUL, 32'ha);
		// Plain levels, debounce and bounce rejection
		for (int k = 0; k < 3; k++)
		begin
			cfg(8'h80, kinds[k]);
			drive(4'h1);
			ms(2);
			check("early", block_out, 32'h0);
			wait_pin("level high", 1'b0, 1'b1);
			drive(4'h0);
			ms(1);
			drive(4'h1);
			ms(5);
			check("bounce", block_out, 32'h1);
			drive(4'h0);
			wait_pin("level low", 1'b0, 1'b0);
		end
		master_unit <= 1'b0;
		cfg(8'h80, 6'h20);
		drive(4'h1);
		ms(8);
		check("chain off master", block_out, 32'h0);
		bus(1'b0, sie_pkg::OFS_STATUS, 32'h0);
		check("config fault", rd[4], 32'h1);
		master_unit <= 1'b1;
		// Double chained line needs both lines high
		cfg(8'h81, 6'h20);
		drive(4'h1);
		ms(8);
		check("chain half", block_out, 32'h0);
		drive(4'h3);
		wait_pin("chain double", 1'b0, 1'b1);
		// Mat with test pulses and a short on the first line
		mat_mode <= 1'b1;
		cfg(8'hb0, 6'h04);
		drive(4'h3);
		wait_pin("mat clear", 1'b0, 1'b1);
		drive(4'h0);
		wait_pin("mat occupied", 1'b0, 1'b0);
		drive(4'h3);
		wait_pin("mat again", 1'b0, 1'b1);
		short_mode <= 1'b1;
		wait_pin("short fault", 1'b1, 1'b1);
		check("short out", block_out, 32'h0);
		short_mode <= 1'b0;
		wait_pin("short gone", 1'b1, 1'b0);
		mat_mode <= 1'b0;
		drive(4'h0);
		// Manual then monitored reset
		for (int m = 0; m < 2; m++)
		begin
			cfg(m ? 8'h86 : 8'h82, 6'h02);
			drive(4'h1);
			ms(8);
			check("locked", block_out, 32'h0);
			press(1'b1);
			ms(8);
			check("after rise", block_out, {31'h0, m == 0});
			press(1'b0);
			wait_pin("released", 1'b0, 1'b1);
			drive(4'h0);
			wait_pin("cond low", 1'b0, 1'b0);
			drive(4'h1);
			ms(8);
			check("relocked", block_out, 32'h0);
		end
		// Two-hand inside and outside the window
		cfg(8'h80, 6'h01);
		drive(4'h1);
		ms(100);
		drive(4'h3);
		wait_pin("two hand", 1'b0, 1'b1);
		drive(4'h0);
		wait_pin("two hand off", 1'b0, 1'b0);
		drive(4'h1);
		ms(600);
		drive(4'h3);
		ms(8);
		check("two hand late", block_out, 32'h0);
		drive(4'h0);
		// Quad two-hand: NO on first and third, NC on second and fourth
		cfg(8'h81, 6'h01);
		drive(4'ha);
		ms(8);
		drive(4'h5);
		wait_pin("quad two hand", 1'b0, 1'b1);
		drive(4'ha);
		wait_pin("quad off", 1'b0, 1'b0);
		drive(4'h0);
		// Grip positions and simultaneity
		cfg(8'h91, 6'h10);
		for (int p = 0; p < 4; p++)
		begin
			drive({1'b0, pos[p]});
			ms(6);
			check("grip", block_out, {31'h0, grip_out(pos[p])});
		end
		drive(4'h4);
		ms(6);
		drive(4'h5);
		wait_pin("simul fault", 1'b1, 1'b1);
		check("simul out", block_out, 32'h0);
		drive(4'h4);
		wait_pin("simul gone", 1'b1, 1'b0);
		// Start-up test after a fresh reset
		@(posedge clk);
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		cfg(8'h88, 6'h08);
		drive(4'h1);
		ms(8);
		check("startup hold", block_out, 32'h0);
		drive(4'h0);
		ms(8);
		drive(4'h1);
		wait_pin("startup done", 1'b0, 1'b1);
		bus(1'b0, sie_pkg::OFS_STATUS, 32'h0);
		check("startup flag", rd[sie_pkg::ST_SU_BIT], 32'h1);
		summarize();
	end

	// Watchdog
	initial
	begin
		repeat (80000) @(posedge clk);
		fail_count++;
		summarize();
	end
endmodule

bind sie_input_evaluator sie_input_evaluator_props #(.TICK_CYCLES(TICK_CYCLES)) props_i (
	.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.test_pulse_out(test_pulse_out), .block_out(block_out), .fault_out(fault_out));

`default_nettype wire
